/* shared/evq_pkg.sv */
/*
  Shared constants and types for the event ordering and event queue unit.
  Assumes a 32-bit AXI4-Lite register port and an 8-bit byte address.
*/
`default_nettype none
package evq_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_PROD = 8'h00;
  localparam logic [7:0] OFF_CONS = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam int         OVF_BIT  = 31;
  // Control and status bit positions
  localparam int CTRL_EVQ_EN  = 0;
  localparam int CTRL_XL_EN   = 1;
  localparam int CTRL_CHK_EN  = 2;
  localparam int CTRL_REC_ATS = 3;
  localparam int ST_FULL      = 0;
  localparam int ST_OVF       = 1;
  localparam int ST_HOLD      = 2;
  localparam int ST_HSTALL    = 3;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Configuration fault vector, index is priority
  localparam int CFG_N       = 9;
  localparam int CF_UNKNOWN  = 0;
  localparam int CF_STE_ABT  = 1;
  localparam int CF_BAD_STE  = 2;
  localparam int CF_VMS_ABT  = 3;
  localparam int CF_BAD_SUB  = 4;
  localparam int CF_DISABLED = 5;
  localparam int CF_CTX_S2   = 6;
  localparam int CF_CTX_ABT  = 7;
  localparam int CF_BAD_CTX  = 8;
  // Walk fault vector for one level, index is priority
  localparam int WF_N       = 18;
  localparam int WF_S2D_LO  = 1;
  localparam int WF_S2D_HI  = 6;
  localparam int WF_S1_LO   = 7;
  localparam int WF_S1_HI   = 11;
  localparam int WF_S2F_LO  = 12;
  localparam int WF_S2_STEP = 6;
  localparam int QLOG_DEF   = 4;
  localparam int SIDW_DEF   = 16;

  typedef enum logic [4:0] {
    ev_none, unknown_stream_error, stream_entry_fetch_abort,
    invalid_stream_entry, vm_structure_fetch_abort,
    invalid_substream_error, disabled_stream_fault, context_fetch_abort,
    invalid_context_error, translation_fault, addr_size_fault,
    access_fault, permission_fault, walk_external_abort,
    tlb_conflict_fault, cfg_conflict_fault,
    unsupported_transaction_fault, bad_translation_request,
    translated_forbidden_fault
  } event_t;

  typedef enum logic [1:0] {
    txn_ordinary, txn_ats_request, txn_ats_translated
  } txn_kind_t;

  typedef enum logic [1:0] {
    resp_pass, resp_abort, resp_stall, resp_silent
  } resp_t;
endpackage : evq_pkg
`default_nettype wire

/* logic/evq_fault_unit.sv */
/*
  Event ordering and event queue producer with AXI4-Lite registers.
  Assumes the walker and config fetch report one flag vector per
  transaction, and a memory writer that acks each record write.
*/
`default_nettype none
module evq_fault_unit #(
  parameter int QLOG = evq_pkg::QLOG_DEF,
  parameter int SIDW = evq_pkg::SIDW_DEF
) (
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        reset,
  // AXI4-Lite slave
  input  wire logic [7:0]                  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [7:0]                  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // Transaction fault report
  input  wire logic                        rep_valid,
  output logic                             rep_ready,
  input  wire evq_pkg::txn_kind_t          rep_kind,
  input  wire logic [SIDW-1:0]             rep_stream,
  input  wire logic [evq_pkg::CFG_N-1:0]   rep_cfg_flt,
  input  wire logic [evq_pkg::WF_N-1:0]    rep_walk_flt,
  input  wire logic                        rep_unsupported,
  input  wire logic                        rep_tlb_conflict,
  input  wire logic                        rep_cfg_conflict,
  input  wire logic                        rep_ats_forbid,
  input  wire logic                        rep_stall_cfg,
  input  wire logic                        rep_s2_select,
  // Answer to the client
  output logic                             resp_valid,
  output evq_pkg::resp_t                   resp_kind,
  output evq_pkg::event_t                  resp_event,
  // Record write to queue memory
  output logic                             rec_valid,
  input  wire logic                        rec_ready,
  output logic [QLOG-1:0]                  rec_slot,
  output evq_pkg::event_t                  rec_event,
  output logic [SIDW-1:0]                  rec_stream,
  output logic                             rec_stall
);

  ////////////////////////////////////////////////////////////////////////
  logic [QLOG:0]   prod_r, cons_r;
  logic            overflow_flag_r, ovack_r;
  logic [31:0]     ctrl_r;
  logic            hold_valid_r, hold_stall_r;
  evq_pkg::event_t hold_event_r;
  logic [SIDW-1:0] hold_stream_r;
  logic            en, full, ovf_present, start_wr, discard, accept;
  evq_pkg::event_t ev_nxt;
  evq_pkg::resp_t  rk_nxt;
  logic            stall_nxt;

  function automatic evq_pkg::event_t cfg_event(input int idx);
    case (idx)
      evq_pkg::CF_UNKNOWN:  return evq_pkg::unknown_stream_error;
      evq_pkg::CF_STE_ABT:  return evq_pkg::stream_entry_fetch_abort;
      evq_pkg::CF_BAD_STE:  return evq_pkg::invalid_stream_entry;
      evq_pkg::CF_VMS_ABT:  return evq_pkg::vm_structure_fetch_abort;
      evq_pkg::CF_BAD_SUB:  return evq_pkg::invalid_substream_error;
      evq_pkg::CF_DISABLED: return evq_pkg::disabled_stream_fault;
      evq_pkg::CF_CTX_ABT:  return evq_pkg::context_fetch_abort;
      default:              return evq_pkg::invalid_context_error;
    endcase
  endfunction : cfg_event

  // Walk step to event; stage-2 groups share one step pattern
  function automatic evq_pkg::event_t walk_event(input int idx);
    int step;
    step = 0;
    if (idx >= evq_pkg::WF_S2F_LO)
      step = idx - evq_pkg::WF_S2F_LO;
    else if (idx >= evq_pkg::WF_S2D_LO && idx <= evq_pkg::WF_S2D_HI)
      step = idx - evq_pkg::WF_S2D_LO;
    else if (idx >= evq_pkg::WF_S1_LO)
      step = idx - evq_pkg::WF_S1_LO + 1;
    case (step)
      0:       return evq_pkg::translation_fault;
      1:       return evq_pkg::walk_external_abort;
      2:       return evq_pkg::translation_fault;
      3:       return evq_pkg::addr_size_fault;
      4:       return evq_pkg::access_fault;
      default: return evq_pkg::permission_fault;
    endcase
  endfunction : walk_event

  function automatic logic stallable(input evq_pkg::event_t e);
    return e == evq_pkg::translation_fault || e == evq_pkg::addr_size_fault
        || e == evq_pkg::access_fault || e == evq_pkg::permission_fault;
  endfunction : stallable

  function automatic logic [31:0] merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
      if (strb[b]) r[8*b +: 8] = new_v[8*b +: 8];
    return r;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////
  // Event selection for one transaction
  always_comb begin
    int              ci, wi;
    logic            ch, wh, ws2, any;
    evq_pkg::event_t wev;
    ci = 0;
    wi = 0;
    for (int i = evq_pkg::CFG_N - 1; i >= 0; i--)
      if (rep_cfg_flt[i]) ci = i;
    for (int i = evq_pkg::WF_N - 1; i >= 0; i--)
      if (rep_walk_flt[i]) wi = i;
    ch  = |rep_cfg_flt;
    wh  = |rep_walk_flt;
    wev = walk_event(wi);
    ws2 = (wi >= evq_pkg::WF_S2D_LO && wi <= evq_pkg::WF_S2D_HI)
        || wi >= evq_pkg::WF_S2F_LO;
    any = ch || wh || rep_unsupported || rep_tlb_conflict
        || rep_cfg_conflict || rep_ats_forbid;
    ev_nxt    = evq_pkg::ev_none;
    rk_nxt    = evq_pkg::resp_pass;
    stall_nxt = 1'b0;
    case (rep_kind)
      evq_pkg::txn_ordinary: begin
        if (rep_unsupported)
          ev_nxt = evq_pkg::unsupported_transaction_fault;
        else if (rep_tlb_conflict)
          ev_nxt = evq_pkg::tlb_conflict_fault;
        else if (rep_cfg_conflict)
          ev_nxt = evq_pkg::cfg_conflict_fault;
        else if (ch)
          ev_nxt = (ci == evq_pkg::CF_CTX_S2) ? wev : cfg_event(ci);
        else if (wh)
          ev_nxt = wev;
        stall_nxt = rep_stall_cfg && stallable(ev_nxt);
      end
      evq_pkg::txn_ats_request: begin
        if (any) ev_nxt = evq_pkg::bad_translation_request;
      end
      evq_pkg::txn_ats_translated: begin
        if (rep_ats_forbid)
          ev_nxt = evq_pkg::translated_forbidden_fault;
        else if (ch && (ci == evq_pkg::CF_STE_ABT
            || ci == evq_pkg::CF_VMS_ABT || ci == evq_pkg::CF_CTX_ABT)
            && ctrl_r[evq_pkg::CTRL_XL_EN] && ctrl_r[evq_pkg::CTRL_CHK_EN]
            && ctrl_r[evq_pkg::CTRL_REC_ATS])
          ev_nxt = cfg_event(ci);
        else if (!ch && wh && ws2 && rep_s2_select)
          ev_nxt = wev;
        else if (any)
          rk_nxt = evq_pkg::resp_silent;
      end
      default: ev_nxt = evq_pkg::ev_none;
    endcase
    if (ev_nxt != evq_pkg::ev_none)
      rk_nxt = stall_nxt ? evq_pkg::resp_stall : evq_pkg::resp_abort;
  end

  ////////////////////////////////////////////////////////////////////////
  // Queue state
  assign en          = ctrl_r[evq_pkg::CTRL_EVQ_EN];
  assign full        = prod_r[QLOG-1:0] == cons_r[QLOG-1:0]
                    && prod_r[QLOG] != cons_r[QLOG];
  assign ovf_present = overflow_flag_r != ovack_r;
  assign start_wr    = hold_valid_r && !rec_valid && en && !full;
  assign discard     = hold_valid_r && !rec_valid && !hold_stall_r
                    && (!en || full);
  assign rep_ready   = !hold_valid_r;
  assign accept      = rep_valid && rep_ready;
  assign rec_slot    = prod_r[QLOG-1:0];
  assign rec_event   = hold_event_r;
  assign rec_stream  = hold_stream_r;
  assign rec_stall   = hold_stall_r;

  always_ff @(posedge clock) begin
    if (reset) begin
      resp_valid <= 1'b0;
      resp_kind  <= evq_pkg::resp_pass;
      resp_event <= evq_pkg::ev_none;
    end else begin
      resp_valid <= accept;
      resp_kind  <= rk_nxt;
      resp_event <= ev_nxt;
    end
  end

  // Pending record; a stall record waits here for space
  always_ff @(posedge clock) begin
    if (reset) begin
      hold_valid_r  <= 1'b0;
      hold_stall_r  <= 1'b0;
      hold_event_r  <= evq_pkg::ev_none;
      hold_stream_r <= '0;
    end else if (accept) begin
      hold_valid_r  <= ev_nxt != evq_pkg::ev_none;
      hold_stall_r  <= stall_nxt;
      hold_event_r  <= ev_nxt;
      hold_stream_r <= rep_stream;
    end else if (discard || (rec_valid && rec_ready)) begin
      hold_valid_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset)
      rec_valid <= 1'b0;
    else if (rec_valid && rec_ready)
      rec_valid <= 1'b0;
    else if (start_wr)
      rec_valid <= 1'b1;
  end

  // Index passes the entry only after the write is acknowledged
  always_ff @(posedge clock) begin
    if (reset)
      prod_r <= '0;
    else if (rec_valid && rec_ready)
      prod_r <= prod_r + 1'b1;
  end

  // Full seen from the already published index
  always_ff @(posedge clock) begin
    if (reset)
      overflow_flag_r <= 1'b0;
    else if (discard && en && full && !ovf_present)
      overflow_flag_r <= ~overflow_flag_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic       aw_got_r, w_got_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        do_wr;

  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_wr         = aw_got_r && w_got_r && !s_axi_bvalid;

  always_ff @(posedge clock) begin
    if (reset) begin
      aw_got_r  <= 1'b0;
      aw_addr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_r  <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_got_r  <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      w_got_r  <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_r  <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (do_wr) begin
      w_got_r  <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= evq_pkg::RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr_r == evq_pkg::OFF_PROD
                    || aw_addr_r == evq_pkg::OFF_CONS
                    || aw_addr_r == evq_pkg::OFF_CTRL
                    || aw_addr_r == evq_pkg::OFF_STAT)
                    ? evq_pkg::RESP_OKAY : evq_pkg::RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Consumer index and acknowledge written by software
  logic [31:0] cons_m;
  assign cons_m = merge({ovack_r, {(31 - QLOG - 1){1'b0}}, cons_r},
                        w_data_r, w_strb_r);

  always_ff @(posedge clock) begin
    if (reset) begin
      cons_r  <= '0;
      ovack_r <= 1'b0;
    end else if (do_wr && aw_addr_r == evq_pkg::OFF_CONS) begin
      cons_r  <= cons_m[QLOG:0];
      ovack_r <= cons_m[evq_pkg::OVF_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (reset)
      ctrl_r <= evq_pkg::CTRL_RST;
    else if (do_wr && aw_addr_r == evq_pkg::OFF_CTRL)
      ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= evq_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= evq_pkg::RESP_OKAY;
      s_axi_rdata  <= '0;
      case (s_axi_araddr)
        evq_pkg::OFF_PROD:
          s_axi_rdata <= {overflow_flag_r, {(31 - QLOG - 1){1'b0}}, prod_r};
        evq_pkg::OFF_CONS:
          s_axi_rdata <= {ovack_r, {(31 - QLOG - 1){1'b0}}, cons_r};
        evq_pkg::OFF_CTRL:
          s_axi_rdata <= {28'h0000000, ctrl_r[3:0]};
        evq_pkg::OFF_STAT:
          s_axi_rdata <= {28'h0000000, hold_stall_r, hold_valid_r,
                          ovf_present, full};
        default:
          s_axi_rresp <= evq_pkg::RESP_DECERR;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_first_cfg;
    accept && rep_kind == evq_pkg::txn_ordinary && rep_cfg_flt[0]
      && !rep_unsupported && !rep_tlb_conflict && !rep_cfg_conflict
      |=> resp_event == evq_pkg::unknown_stream_error;
  endproperty
  a_first_cfg: assert property (p_first_cfg)
    else $error("wrong first configuration event");

  property p_ats_req;
    resp_valid && $past(rep_kind) == evq_pkg::txn_ats_request
      |-> resp_event inside {evq_pkg::ev_none,
                             evq_pkg::bad_translation_request};
  endproperty
  a_ats_req: assert property (p_ats_req)
    else $error("translation request raised other event");

  property p_full_block;
    $rose(rec_valid) |-> $past(en) && !$past(full);
  endproperty
  a_full_block: assert property (p_full_block)
    else $error("record started while full or disabled");

  property p_slot;
    rec_valid && !rec_ready |=> rec_slot == $past(rec_slot);
  endproperty
  a_slot: assert property (p_slot)
    else $error("producer index moved before write done");

  property p_ovf_cause;
    $changed(overflow_flag_r) |-> $past(en && full && discard);
  endproperty
  a_ovf_cause: assert property (p_ovf_cause)
    else $error("overflow without dropped record");

  property p_stall_kept;
    hold_valid_r && hold_stall_r && full && !rec_valid |=> hold_valid_r;
  endproperty
  a_stall_kept: assert property (p_stall_kept)
    else $error("stall record lost");

  property p_dis_no_ovf;
    !en |=> $stable(overflow_flag_r);
  endproperty
  a_dis_no_ovf: assert property (p_dis_no_ovf)
    else $error("overflow while disabled");

  property p_no_retoggle;
    ovf_present && $stable(ovack_r) ##1 $stable(ovack_r)
      |-> $stable(overflow_flag_r);
  endproperty
  a_no_retoggle: assert property (p_no_retoggle)
    else $error("overflow flag toggled while present");

  property p_deliver;
    hold_valid_r && !rec_valid && en && !full |=> rec_valid;
  endproperty
  a_deliver: assert property (p_deliver)
    else $error("record not delivered with space");

  logic rec_stall_q;
  always_ff @(posedge clock) rec_stall_q <= stall_nxt;
  property p_abort;
    resp_valid && resp_event != evq_pkg::ev_none
      |-> resp_kind == (rec_stall_q ? evq_pkg::resp_stall
                                    : evq_pkg::resp_abort);
  endproperty
  a_abort: assert property (p_abort)
    else $error("event did not abort or stall");

  property p_advance;
    rec_valid && rec_ready |=> prod_r == $past(prod_r) + 1'b1;
  endproperty
  a_advance: assert property (p_advance)
    else $error("producer index not advanced");

  c_write:  cover property (rec_valid && rec_ready);
  c_ovf:    cover property ($changed(overflow_flag_r));
  c_stallf: cover property (hold_valid_r && hold_stall_r && full);

endmodule : evq_fault_unit
`default_nettype wire

/* bench/evq_mem_model.sv */
/*
  Queue memory model: acknowledges record writes, prompt and slow in turn.
  Assumes one record offered at a time on the record port.
*/
`default_nettype none
module evq_mem_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // Record port
  input  wire logic       rec_valid,
  output logic            rec_ready,
  input  wire logic [3:0] rec_slot,
  // Observation
  output int              n_rec,
  output logic [3:0]      last_slot
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_r;
  logic       slow_r;
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (reset) begin
      rec_ready <= 1'b0;
      wait_r    <= 2'h0;
      slow_r    <= 1'b0;
      n_rec     <= 0;
      last_slot <= 4'h0;
    end else if (rec_valid && rec_ready) begin
      rec_ready <= 1'b0;
      n_rec     <= n_rec + 1;
      last_slot <= rec_slot;
      slow_r    <= !slow_r;
      wait_r    <= 2'h0;
    end else if (rec_valid) begin
      wait_r <= wait_r + 2'h1;
      if (!slow_r || wait_r == 2'h2) begin
        rec_ready <= 1'b1;
      end
    end
  end
endmodule : evq_mem_model
`default_nettype wire

/* bench/event_queue_fault_priority_tb.sv */
/*
  Self-checking bench for the event ordering and event queue unit.
  Assumes the queue memory model on the record port.
*/
`default_nettype none
module event_queue_fault_priority_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clock, reset, awvalid, awready, wvalid, wready;
  logic               bvalid, bready, arvalid, arready, rvalid, rready;
  logic               rep_valid, rep_ready, stall_cfg, resp_valid, s2sel;
  logic [20:0]        last_rec;
  logic               rec_valid, rec_ready, rec_stall;
  logic [7:0]         awaddr, araddr;
  logic [31:0]        wdata, rdata;
  logic [1:0]         bresp, rresp;
  logic [8:0]         cfg;
  logic [17:0]        walk;
  logic [3:0]         xf, rec_slot, last_slot;
  logic [15:0]        rec_stream;
  evq_pkg::txn_kind_t kind;
  evq_pkg::resp_t     resp_kind;
  evq_pkg::event_t    resp_event, rec_event;
  int                 n_fail, cmp_count, n_rec;

  evq_fault_unit i_evq_fault_unit (.clock(clock), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rep_valid(rep_valid),
    .rep_ready(rep_ready), .rep_kind(kind), .rep_stream(16'h0001),
    .rep_cfg_flt(cfg), .rep_walk_flt(walk), .rep_unsupported(xf[3]),
    .rep_tlb_conflict(xf[2]), .rep_cfg_conflict(xf[1]),
    .rep_ats_forbid(xf[0]), .rep_stall_cfg(stall_cfg),
    .rep_s2_select(s2sel), .resp_valid(resp_valid), .resp_kind(resp_kind),
    .resp_event(resp_event), .rec_valid(rec_valid), .rec_ready(rec_ready),
    .rec_slot(rec_slot), .rec_event(rec_event), .rec_stream(rec_stream),
    .rec_stall(rec_stall));
  evq_mem_model i_evq_mem_model (.clock(clock), .reset(reset),
    .rec_valid(rec_valid), .rec_ready(rec_ready), .rec_slot(rec_slot),
    .n_rec(n_rec), .last_slot(last_slot));

  always #12.5 clock = ~clock;
  // Last record taken by the queue memory
  always @(posedge clock)
    if (rec_valid && rec_ready) last_rec <= {rec_event, rec_stream};
  ////////////////////////////////////////////////////////////////////////
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    int   n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clock);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      if (tb) chk("bresp", 32'(evq_pkg::RESP_OKAY), 32'(bresp));
      @(posedge clock);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      n++;
    end while (!tb && n < 40);
    if (!tb) n_fail++;
  endtask : axi_wr

  task axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    logic ta, tb;
    int   n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clock);
      ta = arvalid && arready;
      tb = rvalid;
      if (tb) chk("rdata", e, rdata);
      if (tb) chk("rresp", 32'(r), 32'(rresp));
      @(posedge clock);
      if (ta) arvalid <= 1'b0;
      n++;
    end while (!tb && n < 40);
    if (!tb) n_fail++;
  endtask : axi_rd

  task rep(input evq_pkg::txn_kind_t k, input logic [8:0] c,
           input logic [17:0] w, input logic [3:0] x, input logic s,
           input evq_pkg::resp_t ek, input evq_pkg::event_t ee);
    logic t;
    int   n;
    n = 0;
    kind <= k;
    cfg <= c;
    walk <= w;
    xf <= x;
    stall_cfg <= s;
    rep_valid <= 1'b1;
    do begin
      @(negedge clock);
      t = rep_ready;
      @(posedge clock);
      n++;
    end while (t !== 1'b1 && n < 40);
    rep_valid <= 1'b0;
    @(negedge clock);
    chk("resp_valid", 32'h1, 32'(resp_valid));
    chk("resp_kind", 32'(ek), 32'(resp_kind));
    if (ek != evq_pkg::resp_silent) chk("resp_event", 32'(ee), 32'(resp_event));
    @(posedge clock);
  endtask : rep

  task wait_rec(input int e, input logic [3:0] sl,
                input evq_pkg::event_t ee);
    int n;
    n = 0;
    while (n_rec != e && n < 20) begin
      @(negedge clock);
      n++;
    end
    chk("records", 32'(e), 32'(n_rec));
    chk("rec_slot", 32'(sl), 32'(last_slot));
    if (e > 0) chk("record", 32'({ee, 16'h0001}), 32'(last_rec));
    @(posedge clock);
  endtask : wait_rec
  ////////////////////////////////////////////////////////////////////////
  task t_prio;
    axi_rd(evq_pkg::OFF_CTRL, 32'h0, evq_pkg::RESP_OKAY);
    axi_rd(8'h10, 32'h0, evq_pkg::RESP_DECERR);
    rep(evq_pkg::txn_ordinary, 9'h00C, 18'h0, 4'h0, 1'b0, evq_pkg::resp_abort,
        evq_pkg::invalid_stream_entry);
    rep(evq_pkg::txn_ordinary, 9'h018, 18'h0, 4'h0, 1'b0, evq_pkg::resp_abort,
        evq_pkg::vm_structure_fetch_abort);
    rep(evq_pkg::txn_ordinary, 9'h001, 18'h0, 4'h8, 1'b0, evq_pkg::resp_abort,
        evq_pkg::unsupported_transaction_fault);
    axi_rd(evq_pkg::OFF_STAT, 32'h0, evq_pkg::RESP_OKAY);
    wait_rec(0, 4'h0, evq_pkg::ev_none);
    $display("test priority done");
  endtask : t_prio

  task t_walk;
    axi_wr(evq_pkg::OFF_CTRL, 32'h1);
    rep(evq_pkg::txn_ordinary, 9'h0, 18'h00480, 4'h0, 1'b0,
        evq_pkg::resp_abort, evq_pkg::walk_external_abort);
    wait_rec(1, 4'h0, evq_pkg::walk_external_abort);
    rep(evq_pkg::txn_ordinary, 9'h0, 18'h00082, 4'h0, 1'b0,
        evq_pkg::resp_abort, evq_pkg::translation_fault);
    wait_rec(2, 4'h1, evq_pkg::translation_fault);
    rep(evq_pkg::txn_ordinary, 9'h0, 18'h01000, 4'h0, 1'b0,
        evq_pkg::resp_abort, evq_pkg::translation_fault);
    wait_rec(3, 4'h2, evq_pkg::translation_fault);
    rep(evq_pkg::txn_ats_request, 9'h0, 18'h00001, 4'h0, 1'b0,
        evq_pkg::resp_abort, evq_pkg::bad_translation_request);
    wait_rec(4, 4'h3, evq_pkg::bad_translation_request);
    rep(evq_pkg::txn_ats_translated, 9'h004, 18'h0, 4'h0, 1'b0,
        evq_pkg::resp_silent, evq_pkg::ev_none);
    axi_rd(evq_pkg::OFF_PROD, 32'h4, evq_pkg::RESP_OKAY);
    $display("test walk done");
  endtask : t_walk

  task t_ovf;
    axi_wr(evq_pkg::OFF_CONS, 32'h14);
    axi_rd(evq_pkg::OFF_STAT, 32'h1, evq_pkg::RESP_OKAY);
    rep(evq_pkg::txn_ordinary, 9'h001, 18'h0, 4'h0, 1'b0,
        evq_pkg::resp_abort, evq_pkg::unknown_stream_error);
    axi_rd(evq_pkg::OFF_PROD, 32'h8000_0004, evq_pkg::RESP_OKAY);
    axi_rd(evq_pkg::OFF_STAT, 32'h3, evq_pkg::RESP_OKAY);
    rep(evq_pkg::txn_ordinary, 9'h001, 18'h0, 4'h0, 1'b0,
        evq_pkg::resp_abort, evq_pkg::unknown_stream_error);
    axi_rd(evq_pkg::OFF_PROD, 32'h8000_0004, evq_pkg::RESP_OKAY);
    axi_wr(evq_pkg::OFF_CONS, 32'h04);
    rep(evq_pkg::txn_ordinary, 9'h0, 18'h00080, 4'h0, 1'b0,
        evq_pkg::resp_abort, evq_pkg::walk_external_abort);
    wait_rec(5, 4'h4, evq_pkg::walk_external_abort);
    axi_wr(evq_pkg::OFF_CONS, 32'h8000_0005);
    axi_rd(evq_pkg::OFF_STAT, 32'h0, evq_pkg::RESP_OKAY);
    $display("test overflow done");
  endtask : t_ovf

  task t_stall;
    axi_wr(evq_pkg::OFF_CTRL, 32'h0);
    rep(evq_pkg::txn_ordinary, 9'h0, 18'h00400, 4'h0, 1'b1,
        evq_pkg::resp_stall, evq_pkg::access_fault);
    axi_rd(evq_pkg::OFF_STAT, 32'hC, evq_pkg::RESP_OKAY);
    chk("rep_ready", 32'h0, 32'(rep_ready));
    chk("rec_stall", 32'h1, 32'(rec_stall));
    axi_wr(evq_pkg::OFF_CTRL, 32'h1);
    wait_rec(6, 4'h5, evq_pkg::access_fault);
    axi_rd(evq_pkg::OFF_PROD, 32'h8000_0006, evq_pkg::RESP_OKAY);
    $display("test stall done");
  endtask : t_stall

  task t_ats;
    axi_wr(evq_pkg::OFF_CTRL, 32'hF);
    s2sel <= 1'b1;
    rep(evq_pkg::txn_ats_translated, 9'h0, 18'h01000, 4'h0, 1'b0,
        evq_pkg::resp_abort, evq_pkg::translation_fault);
    wait_rec(7, 4'h6, evq_pkg::translation_fault);
    rep(evq_pkg::txn_ats_translated, 9'h002, 18'h0, 4'h1, 1'b0,
        evq_pkg::resp_abort, evq_pkg::translated_forbidden_fault);
    wait_rec(8, 4'h7, evq_pkg::translated_forbidden_fault);
    rep(evq_pkg::txn_ats_translated, 9'h002, 18'h0, 4'h0, 1'b0,
        evq_pkg::resp_abort, evq_pkg::stream_entry_fetch_abort);
    wait_rec(9, 4'h8, evq_pkg::stream_entry_fetch_abort);
    $display("test translated done");
  endtask : t_ats

  task stop_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {clock, awvalid, wvalid, bready, arvalid, rready} = '0;
    {rep_valid, stall_cfg, s2sel, awaddr, araddr, wdata, cfg, walk, xf} = '0;
    kind = evq_pkg::txn_ordinary;
    reset = 1'b1;
    n_fail = 0;
    cmp_count = 0;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_prio();
    t_walk();
    t_ovf();
    t_stall();
    t_ats();
    stop_test();
  end

  initial begin
    repeat (5000) @(posedge clock);
    n_fail++;
    stop_test();
  end
endmodule : event_queue_fault_priority_tb
`default_nettype wire
